// *** core/tc1_consts.vh ***
/*
 Constants for the 16-bit timer/counter one: register offsets, field
 positions, reset values and timing figures.
 Assumes inclusion by bare name from design files.
*/
`ifndef TC1_CONSTS_VH
`define TC1_CONSTS_VH

// ------------------------------------------------------------
// Register offsets (plain register port, byte wide data)
// ------------------------------------------------------------
`define TC1_ADDR_W 3
`define TC1_OFF_CTRL 3'h0
`define TC1_OFF_LOW 3'h1
`define TC1_OFF_HIGH 3'h2
`define TC1_OFF_STAT 3'h3
`define TC1_OFF_MASK 3'h4

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define TC1_B_WIDE 7
`define TC1_B_DIV_HI 5
`define TC1_B_DIV_LO 4
`define TC1_B_OSC 3
`define TC1_B_NOSYNC 2
`define TC1_B_SRC 1
`define TC1_B_RUN 0
`define TC1_CTRL_WMASK 8'hbf

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define TC1_CTRL_RST 8'h00
`define TC1_CNT_MAX 16'hffff
`define TC1_CYC_PER_INSTR 4
`define TC1_OSC_MAX_KHZ 200

`endif

// *** core/tc1_timer.v ***
/*
 Holds the 16-bit timer/counter one with prescaler, source select,
 external edge handling, wide access buffer, overflow interrupt and
 crystal oscillator control outputs.
 Assumes a byte register port synchronous to clk_sys, a one-cycle
 compare trigger pulse, and the count pin and crystal input already
 at logic levels synchronous to clk_sys.
*/
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "tc1_consts.vh"

// How it works
// - Counter advances only while the run bit is set; clearing holds value.
// - Sixteen-bit count in two bytes; rollover to zero sets sticky flag.
// - Compare unit trigger pulse clears the counter.
// - Wide bit clear gives two byte accesses; set gives buffered word access.
// - Divide field picks prescale of one, two, four or eight.
// - Oscillator enable bit turns crystal amplifier on, off when clear.
// - With external source, sync bit zero synchronises, one bypasses; else ignored.
// - Internal source counts once per instruction cycle, clock divided by four.
// - External source counts rising edges of pin or crystal oscillator.
// - Oscillator enabled forces both crystal pins input, reads return zero.
// - Oscillator keeps running in sleep so unsynchronised counting continues.
// - Wide mode low byte read latches live high into buffer read at high.
// - Wide mode high write goes to buffer; copied to count with low write.
// - Low byte write clears prescaler; high byte write never does.
// - Software counter write beats a simultaneous compare trigger.
module tc1_timer (
   input wire clk_sys,
   input wire reset_n,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   input wire compare_unit_one_trigger,
   input wire external_count_pin,
   input wire crystal_in_pin,
   input wire sleep_mode,
   input wire [1:0] port_c_direction,
   input wire [1:0] port_c_pin_in,
   output wire [1:0] port_c_dir_effective,
   output wire [1:0] port_c_read_value,
   output wire crystal_amp_enable,
   output wire crystal_out_pin_o,
   output wire crystal_out_pin_oe,
   output wire irq
);

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   function hit;
      input [2:0] a;
      input [2:0] off;
      input s;
      begin
         hit = s && (a == off);
      end
   endfunction

   reg [7:0] ctrl_q;
   reg [15:0] cnt_q;
   reg [7:0] hbuf_q;
   reg [2:0] pre_q;
   reg [1:0] q4_q;
   reg flag_q;
   reg mask_q;
   reg ext_meta_q;
   reg ext_sync_q;
   reg ext_prev_q;
   reg clk_prev_q;

   wire wide = ctrl_q[`TC1_B_WIDE];
   wire [1:0] div_sel = ctrl_q[`TC1_B_DIV_HI:`TC1_B_DIV_LO];
   wire osc_en = ctrl_q[`TC1_B_OSC];
   wire no_sync = ctrl_q[`TC1_B_NOSYNC];
   wire src_ext = ctrl_q[`TC1_B_SRC];
   wire run = ctrl_q[`TC1_B_RUN];

   wire wr_ctrl = hit(reg_addr, `TC1_OFF_CTRL, reg_write);
   wire wr_low = hit(reg_addr, `TC1_OFF_LOW, reg_write);
   wire wr_high = hit(reg_addr, `TC1_OFF_HIGH, reg_write);
   wire wr_stat = hit(reg_addr, `TC1_OFF_STAT, reg_write);
   wire wr_mask = hit(reg_addr, `TC1_OFF_MASK, reg_write);
   wire rd_low = hit(reg_addr, `TC1_OFF_LOW, reg_read);

   // ------------------------------------------------------------
   // Crystal oscillator and pins
   // ------------------------------------------------------------
   // Amplifier held on through sleep; only the enable bit stops it
   assign crystal_amp_enable = osc_en;
   assign crystal_out_pin_o = osc_en & ~crystal_in_pin;
   assign crystal_out_pin_oe = osc_en;
   assign port_c_dir_effective = osc_en ? 2'h3 : port_c_direction;
   assign port_c_read_value = osc_en ? 2'h0 : port_c_pin_in;

   // Crystal, when on, replaces the pin as the external source
   wire ext_raw = osc_en ? crystal_in_pin : external_count_pin;

   // ------------------------------------------------------------
   // Source select and prescaler
   // ------------------------------------------------------------
   wire instr_tick = (q4_q == 2'h3);
   wire clk_rise = ext_raw & ~clk_prev_q;
   wire src_tick = src_ext ? clk_rise : instr_tick;

   // Prescaler terminal counts for divide by one, two, four and eight
   localparam [2:0] PRE_LIM_DIV1 = 3'h0;
   localparam [2:0] PRE_LIM_DIV2 = 3'h1;
   localparam [2:0] PRE_LIM_DIV4 = 3'h3;
   localparam [2:0] PRE_LIM_DIV8 = 3'h7;

   reg [2:0] pre_lim;
   always @* begin
      case (div_sel)
         2'h0: pre_lim = PRE_LIM_DIV1;
         2'h1: pre_lim = PRE_LIM_DIV2;
         2'h2: pre_lim = PRE_LIM_DIV4;
         default: pre_lim = PRE_LIM_DIV8;
      endcase
   end

   wire pre_out = src_tick && (pre_q == pre_lim);

   // Prescaled edge as a level so the synchroniser sees it
   reg pre_lvl_q;
   // Each prescaled edge toggles the level, so either change is one count
   wire sync_edge = ext_sync_q ^ ext_prev_q;
   wire use_sync = src_ext && !no_sync;
   // Sync bypass still lands in this clock; a true async domain is outside this model
   wire inc = run && (use_sync ? sync_edge : pre_out);

   // ------------------------------------------------------------
   // Counter, buffer, flag
   // ------------------------------------------------------------
   reg [15:0] cnt_d;
   reg ovf;
   always @* begin
      cnt_d = cnt_q;
      ovf = 1'b0;
      if (inc) begin
         cnt_d = cnt_q + 16'h0001;
         ovf = (cnt_q == `TC1_CNT_MAX);
      end
      if (compare_unit_one_trigger) begin
         cnt_d = 16'h0000;
         ovf = 1'b0;
      end
      // Writes come last so they beat the trigger
      if (wr_low) begin
         cnt_d[7:0] = reg_wdata;
         if (wide) begin
            cnt_d[15:8] = hbuf_q;
         end
      end
      if (wr_high && !wide) begin
         cnt_d[15:8] = reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // Next values of the remaining registers
   // ------------------------------------------------------------
   reg [7:0] ctrl_d;
   reg [2:0] pre_d;
   reg pre_lvl_d;
   reg [7:0] hbuf_d;
   reg flag_d;
   reg mask_d;

   always @* begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = reg_wdata & `TC1_CTRL_WMASK;
      end
   end

   always @* begin
      pre_d = pre_q;
      if (wr_low) begin
         pre_d = 3'h0;
      end else if (src_tick && run) begin
         pre_d = (pre_q == pre_lim) ? 3'h0 : pre_q + 3'h1;
      end
   end

   always @* begin
      pre_lvl_d = pre_lvl_q;
      if (pre_out && run) begin
         pre_lvl_d = ~pre_lvl_q;
      end
   end

   always @* begin
      hbuf_d = hbuf_q;
      if (wide && rd_low) begin
         hbuf_d = cnt_q[15:8];
      end else if (wide && wr_high) begin
         hbuf_d = reg_wdata;
      end
   end

   // Set wins over write-one clear so a rollover is never lost
   always @* begin
      flag_d = flag_q;
      if (ovf) begin
         flag_d = 1'b1;
      end else if (wr_stat && reg_wdata[0]) begin
         flag_d = 1'b0;
      end
   end

   always @* begin
      mask_d = mask_q;
      if (wr_mask) begin
         mask_d = reg_wdata[0];
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q4_q <= 2'h0;
      end else begin
         q4_q <= q4_q + 2'h1;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         clk_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= ext_raw;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= `TC1_CTRL_RST;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pre_q <= 3'h0;
         pre_lvl_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         pre_lvl_q <= pre_lvl_d;
      end
   end

   // Only the second and third stages are read downstream; the first may be metastable
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= pre_lvl_q;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hbuf_q <= 8'h00;
      end else begin
         hbuf_q <= hbuf_d;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
      end
   end

   // ------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------
   // Level output; stays high until software clears the flag or the mask bit
   assign irq = flag_q & mask_q;

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   reg [7:0] rdata_d;
   always @* begin
      rdata_d = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            `TC1_OFF_CTRL: rdata_d = ctrl_q;
            `TC1_OFF_LOW: rdata_d = cnt_q[7:0];
            `TC1_OFF_HIGH: rdata_d = wide ? hbuf_q : cnt_q[15:8];
            `TC1_OFF_STAT: rdata_d = {7'h00, flag_q};
            `TC1_OFF_MASK: rdata_d = {7'h00, mask_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Data stand one cycle only and read zero otherwise
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

endmodule

// *** testbench/tc1_partner.sv ***
/* Far side model: compare unit trigger and external count source.
 Assumes requests change just after a rising edge. */
`timescale 1ns/10ps
module tc1_partner (
   input wire clk_sys,
   input wire fire,
   input wire ext_run,
   output reg compare_unit_one_trigger,
   output reg external_count_pin
);
   reg fire_q = 1'b0;
   reg [1:0] tick_q = 2'h0;
   initial compare_unit_one_trigger = 1'b0;
   initial external_count_pin = 1'b0;
   // One pulse per toggle of the request
   always @(posedge clk_sys) begin
      fire_q <= fire;
      compare_unit_one_trigger <= fire ^ fire_q;
      tick_q <= ext_run ? tick_q + 2'h1 : 2'h0;
      // Idles low so no stray edge is counted
      if (!ext_run)
         external_count_pin <= 1'b0;
      else if (tick_q == 2'h2)
         external_count_pin <= ~external_count_pin;
   end
endmodule

// *** testbench/tc1_timer_chk.sv ***
/* Port checker for tc1_timer.
 Assumes one clock domain and a bind onto every tc1_timer. */
`timescale 1ns/10ps
module tc1_timer_chk (
   input wire clk_sys,
   input wire reset_n,
   input wire [2:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_rdata,
   input wire [1:0] port_c_direction,
   input wire [1:0] port_c_dir_effective,
   input wire [1:0] port_c_read_value,
   input wire crystal_amp_enable,
   input wire crystal_out_pin_oe,
   input wire crystal_in_pin,
   input wire crystal_out_pin_o,
   input wire irq
);
   // ----
   // Properties
   // ----
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   AST_DIR: assert property (crystal_amp_enable |-> port_c_dir_effective == 2'h3)
      else $error("pins not forced to input");
   AST_DIRP: assert property (!crystal_amp_enable |-> port_c_dir_effective == port_c_direction)
      else $error("direction not passed");
   AST_PRD: assert property (crystal_amp_enable |-> port_c_read_value == 2'h0)
      else $error("pin read not zero");
   AST_OE: assert property (crystal_out_pin_oe == crystal_amp_enable)
      else $error("amplifier drive wrong");
   AST_XOUT: assert property (crystal_out_pin_o == (crystal_amp_enable & ~crystal_in_pin))
      else $error("amplifier output wrong");
   AST_AMPW: assert property (reg_write && reg_addr == 3'h0 |=> crystal_amp_enable == $past(reg_wdata[3]))
      else $error("oscillator enable not taken");
   AST_RDZ: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data outside slot");
   AST_UNMAP: assert property (reg_read && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_IRQM: assert property (reg_write && reg_addr == 3'h4 && !reg_wdata[0] |=> !irq)
      else $error("masked interrupt high");
   CV_IRQ: cover property (irq);
   CV_OSC: cover property (crystal_amp_enable);
   CV_HIGH: cover property (reg_read && reg_addr == 3'h2);
endmodule

bind tc1_timer tc1_timer_chk u_tc1_timer_chk (.*);

// *** testbench/tc1_timer_test.sv ***
/* Self-checking bench for tc1_timer.
 Assumes the checker is bound in and tc1_partner drives the far side. */
`timescale 1ns/10ps
`include "tc1_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("wrong value at %0t got %h expected %h", $time, g, e); end end
module tc1_timer_test;
   reg clk_sys = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, rd_q = 1'b0;
   reg sleep_mode = 1'b0, crystal_in_pin = 1'b0, fire = 1'b0, ext_run = 1'b0;
   reg [2:0] reg_addr = 3'h0;
   reg [7:0] reg_wdata = 8'h00, d, e;
   reg [1:0] port_c_direction = 2'h0, port_c_pin_in = 2'h0;
   wire [7:0] reg_rdata;
   wire [1:0] port_c_dir_effective, port_c_read_value;
   wire compare_unit_one_trigger, external_count_pin, irq;
   wire crystal_amp_enable, crystal_out_pin_o, crystal_out_pin_oe;
   int failures = 0, comparisons = 0, i, p;
   reg [7:0] exp_q[$];
   tc1_timer u_tc1_timer (.*);
   tc1_partner u_tc1_partner (.*);
   initial forever #25 clk_sys = ~clk_sys;
   // ----
   // Bus cycle; pins get fresh random levels
   // ----
   task bus(input w, input [2:0] a, input [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= w;
      reg_read <= !w;
      if (!w)
         exp_q.push_back(v);
      {crystal_in_pin, sleep_mode, port_c_pin_in, port_c_direction} <= 6'($urandom);
      @(posedge clk_sys);
      reg_write <= 1'b0;
      reg_read <= 1'b0;
   endtask
   task w(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      rd_q <= reg_read;
      if (rd_q) begin
         e = exp_q.pop_front();
         `CHK(reg_rdata, e)
      end
   end
   initial begin
      #300000;
      failures++;
      final_report;
   end
   initial begin
      void'($urandom(32'h4d75));
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      for (i = 0; i < 8; i++) bus(0, i[2:0], 8'h00);
      d = (8'($urandom) | 8'h08) & 8'hfe;
      bus(1, 0, d);
      bus(0, 0, d & `TC1_CTRL_WMASK);
      $display("test 1 finished");
      // Byte mode, then wide mode through the buffer
      bus(1, 0, 0); bus(1, 1, 8'h34); bus(1, 2, 8'h12); bus(0, 1, 8'h34); bus(0, 2, 8'h12);
      bus(1, 0, 8'h80); bus(1, 2, 8'h56); bus(0, 2, 8'h56); bus(1, 1, 8'h78);
      bus(1, 0, 0); bus(0, 2, 8'h56);
      bus(1, 0, 8'h80); bus(1, 2, 8'h9a); bus(0, 1, 8'h78); bus(0, 2, 8'h56);
      fire <= ~fire;
      w(4);
      bus(0, 1, 0); bus(0, 2, 0);
      fire <= ~fire;
      bus(1, 1, 8'h11); bus(0, 1, 8'h11); bus(0, 2, 8'h00);
      $display("test 2 finished");
      // Four increments to rollover at each divide code
      bus(1, 4, 1);
      for (p = 0; p < 4; p++) begin
         bus(1, 0, 0); bus(1, 2, 8'hff); bus(1, 1, 8'hfc); bus(1, 3, 1);
         bus(1, 0, {2'h0, p[1:0], 4'h1});
         w((16 << p) - 8);
         `CHK(irq, 1'b0)
         w(16);
         `CHK(irq, 1'b1)
      end
      bus(1, 0, 0); bus(1, 4, 0); bus(0, 3, 1); bus(1, 3, 1); bus(0, 3, 0);
      $display("test 3 finished");
      // External source, synchronised then bypassed
      bus(1, 4, 1);
      for (p = 0; p < 2; p++) begin
         bus(1, 0, 0); bus(1, 2, 8'hff); bus(1, 1, 8'hfc); bus(1, 3, 1);
         bus(1, 0, {5'h0, p[0], 2'h3});
         w(24);
         `CHK(irq, 1'b0)
         ext_run <= 1'b1;
         w(90);
         ext_run <= 1'b0;
         `CHK(irq, 1'b1)
      end
      $display("test 4 finished");
      final_report;
   end
endmodule
